// file: ffd_accum.sv
// first accumulator of the fraction modulator, carry out per step
// assumes den is nonzero while running; a zero den never carries
`timescale 1ns/1ps
module ffd_accum
#(
	parameter int W = 32
)
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// control
	input  wire logic         hold,     // modulator held in reset
	input  wire logic         load,     // one-cycle reload of start state
	input  wire logic         step,     // detector-rate enable
	input  wire logic [W-1:0] start,    // start state (seed or zero)
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	// result
	output logic              carry
);

	typedef struct packed {
		logic [W-1:0] acc;   // accumulator state
		logic         carry; // overflow of this step
	} ffd_acc_st_t;

	ffd_acc_st_t st_r;
	ffd_acc_st_t st_nxt;
	logic [W:0]  sum;       // one extra bit so the wrap is seen

	// next state: reload, then step modulo den
	always_comb
	begin
		st_nxt = st_r;
		sum    = {1'b0, st_r.acc} + {1'b0, num};
		st_nxt.carry = 1'b0;
		if (hold || load)
		begin
			st_nxt.acc = start;
		end
		else if (step && (den != '0))
		begin
			// carries average num/den per step
			if (sum >= {1'b0, den})
			begin
				st_nxt.acc   = W'(sum - {1'b0, den});
				st_nxt.carry = 1'b1;
			end
			else
			begin
				st_nxt.acc = W'(sum);
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign carry = st_r.carry;

endmodule

// file: ffd_pkg.sv
// shared constants and carrier types for the fractional divider register set
// assumes a 16-bit register port addressed by the printed register offsets
package ffd_pkg;

	// register port geometry
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int FRAC_W = 32;          // numerator, denominator, seed
	localparam int DIV_W  = 19;          // integer feedback divide width

	typedef logic [ADDR_W-1:0] ffd_addr_t;
	typedef logic [DATA_W-1:0] ffd_word_t;

	// register offsets (register port addresses)
	localparam ffd_addr_t OFS_FB_HIGH    = 7'h22;
	localparam ffd_addr_t OFS_FB_LOW     = 7'h24;
	localparam ffd_addr_t OFS_SEED_DELAY = 7'h25;
	localparam ffd_addr_t OFS_DEN_HIGH   = 7'h26;
	localparam ffd_addr_t OFS_DEN_LOW    = 7'h27;
	localparam ffd_addr_t OFS_SEED_HIGH  = 7'h28;
	localparam ffd_addr_t OFS_SEED_LOW   = 7'h29;
	localparam ffd_addr_t OFS_NUM_HIGH   = 7'h2a;
	localparam ffd_addr_t OFS_NUM_LOW    = 7'h2b;
	localparam ffd_addr_t OFS_OUT_MOD    = 7'h2c;
	localparam ffd_addr_t OFS_FIRST_SEL  = 7'h2d;
	localparam ffd_addr_t OFS_SECOND_SEL = 7'h2e;
	localparam ffd_addr_t OFS_PIN_CFG    = 7'h3a;

	// field positions
	localparam int POS_FB_HIGH      = 0;   // divide bits 18:16
	localparam int POS_SEED_EN      = 15;
	localparam int POS_DELAY_SEL    = 8;
	localparam int POS_FIRST_LEVEL  = 8;
	localparam int POS_SECOND_PD    = 7;
	localparam int POS_FIRST_PD     = 6;
	localparam int POS_CLEAR_N      = 5;
	localparam int POS_ORDER        = 0;
	localparam int POS_FIRST_SRC    = 11;
	localparam int POS_BOOST        = 9;
	localparam int POS_SECOND_LEVEL = 0;
	localparam int POS_SECOND_SRC   = 0;
	localparam int POS_PIN_IGNORE   = 15;
	localparam int POS_PIN_HYST     = 14;
	localparam int POS_PIN_LEVEL    = 12;
	localparam int POS_PIN_FORMAT   = 9;

	// reset values
	localparam logic [DIV_W-1:0]  RST_FB_DIVIDE = 19'h0_0064;
	localparam logic [5:0]        RST_DELAY_SEL = 6'h02;
	localparam logic [FRAC_W-1:0] RST_DEN       = 32'hFFFF_FFFF;
	localparam logic [5:0]        RST_LEVEL     = 6'h1F;
	localparam logic [1:0]        RST_SRC       = 2'h1;
	localparam logic [2:0]        RST_ORDER     = 3'h0;

	// constant bit patterns read back in the fixed positions
	localparam ffd_word_t FIX_SEED_DELAY = 16'h0004;
	localparam ffd_word_t FIX_FIRST_SEL  = 16'hC040;
	localparam ffd_word_t FIX_SECOND_SEL = 16'h07FC;
	localparam ffd_word_t FIX_PIN_CFG    = 16'h0001;

	// encodings
	localparam logic [1:0] SRC_HIGH_Z   = 2'h3;
	localparam logic [1:0] SRC_RESERVED = 2'h2;  // first output only
	localparam logic [2:0] ORDER_MAX    = 3'h4;

	// register port request
	typedef struct packed {
		ffd_addr_t addr;
		ffd_word_t wdata;
		logic      wr;
		logic      rd;
	} ffd_bus_t;

	// settings handed to the two output drivers
	typedef struct packed {
		logic [5:0] first_level;
		logic       first_pd;
		logic [1:0] first_src;
		logic       first_active;
		logic [5:0] second_level;
		logic       second_pd;
		logic [1:0] second_src;
		logic       second_active;
		logic [1:0] boost;
	} ffd_out_t;

	// input pin configuration word
	typedef struct packed {
		logic       disregard;
		logic       hysteresis;
		logic [1:0] bias_level;
		logic [2:0] format;
	} ffd_pin_cfg_t;

endpackage

// file: ffd_regs.sv
// register set of the fractional feedback divider and the two rf outputs
// assumes a one-cycle register port and a detector-rate step enable
`timescale 1ns/1ps
module ffd_regs
	import ffd_pkg::*;
(
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	// register port
	input  wire ffd_pkg::ffd_bus_t         bus,
	output logic [ffd_pkg::DATA_W-1:0]     rd_data,
	// modulator step, one pulse per detector cycle
	input  wire logic                      frac_step_en,
	// request pins from the board
	input  wire logic                      sync_pin,
	input  wire logic                      sysref_req_pin,
	// divider and output settings
	output logic [ffd_pkg::DIV_W:0]        feedback_divide,
	output logic                           frac_active,
	output logic [5:0]                     detector_delay_select,
	output ffd_pkg::ffd_out_t              out_ctrl,
	output ffd_pkg::ffd_pin_cfg_t          pin_cfg,
	// request pins after the disregard gate
	output logic                           sync_req,
	output logic                           sysref_req
);
	import ffd_pkg::*;

	// whole state of the register set
	typedef struct packed {
		logic [DIV_W-1:0]  fb_div;        // integer divide value
		logic              seed_en;       // seed apply enable
		logic [5:0]        dly_sel;       // detector delay select
		logic [FRAC_W-1:0] den;           // fraction denominator
		logic [DATA_W-1:0] seed_stage;    // high half awaiting low
		logic [FRAC_W-1:0] seed_acc;      // accumulated seed
		logic [FRAC_W-1:0] num;           // fraction numerator
		logic [5:0]        first_level;
		logic              second_pd;
		logic              first_pd;
		logic              clear_n;       // modulator clear, low active
		logic [2:0]        order;         // modulator order
		logic [1:0]        first_src;
		logic [1:0]        boost;
		logic [5:0]        second_level;
		logic [1:0]        second_src;
		ffd_pin_cfg_t      pin;           // input pin configuration
		logic              seed_load;     // reload pulse to accumulator
		ffd_word_t         rd_data;       // read answer
		logic [DIV_W:0]    div_out;       // effective divide this step
		logic              frac_on;       // fraction path running
		ffd_out_t          out;           // output driver settings
		logic              sync_q;        // gated sync request
		logic              sysref_q;      // gated sysref request
	} ffd_regs_st_t;

	ffd_regs_st_t st_r;
	ffd_regs_st_t st_nxt;
	logic         carry;        // modulator carry for this step

	// an order code 1..4 with the modulator released runs fractions
	function automatic logic frac_allowed(input logic [2:0] order,
	                                      input logic       clear_n);
		frac_allowed = clear_n && (order != 3'h0) && (order <= ORDER_MAX);
	endfunction

	// an output drives when powered up and its source is not hi-z, nor the reserved code where reserved_hiz is set
	function automatic logic out_drives(input logic       pd,
	                                    input logic [1:0] src,
	                                    input logic       reserved_hiz);
		out_drives = !pd && (src != SRC_HIGH_Z) &&
		             !(reserved_hiz && (src == SRC_RESERVED));
	endfunction

	// first accumulator of the modulator
	ffd_accum
	#(
		.W      (FRAC_W)
	)
	u_accum
	(
		.ref_clk (ref_clk),
		.reset   (reset),
		.hold    (!frac_allowed(st_r.order, st_r.clear_n)),
		.load    (st_r.seed_load),
		.step    (frac_step_en),
		.start   (st_r.seed_en ? st_r.seed_acc : '0),
		.num     (st_r.num),
		.den     (st_r.den),
		.carry   (carry)
	);

	// next state: register writes, read answer, derived outputs
	always_comb
	begin
		st_nxt           = st_r;
		st_nxt.seed_load = 1'b0;
		st_nxt.rd_data   = '0;

		// a modulator cleared by clear_n low forgets the seed it had gathered
		if (!st_r.clear_n)
			st_nxt.seed_acc = '0;

		// writes; unmapped addresses are ignored
		if (bus.wr)
		begin
			case (bus.addr)
				OFS_FB_HIGH:
					st_nxt.fb_div[DIV_W-1:16] =
						bus.wdata[POS_FB_HIGH +: 3];
				OFS_FB_LOW:
					st_nxt.fb_div[15:0] = bus.wdata;
				OFS_SEED_DELAY:
				begin
					st_nxt.seed_en = bus.wdata[POS_SEED_EN];
					st_nxt.dly_sel = bus.wdata[POS_DELAY_SEL +: 6];
				end
				OFS_DEN_HIGH:
					st_nxt.den[31:16] = bus.wdata;
				OFS_DEN_LOW:
					st_nxt.den[15:0] = bus.wdata;
				OFS_SEED_HIGH:
					// held until the low half completes the word
					st_nxt.seed_stage = bus.wdata;
				OFS_SEED_LOW:
				begin
					// a write in the clearing cycle still counts
					st_nxt.seed_acc = (st_r.clear_n ? st_r.seed_acc : '0)
					                + {st_r.seed_stage, bus.wdata};
					st_nxt.seed_stage = '0;
					st_nxt.seed_load  = 1'b1;
				end
				OFS_NUM_HIGH:
					st_nxt.num[31:16] = bus.wdata;
				OFS_NUM_LOW:
					st_nxt.num[15:0] = bus.wdata;
				OFS_OUT_MOD:
				begin
					st_nxt.first_level = bus.wdata[POS_FIRST_LEVEL +: 6];
					st_nxt.second_pd   = bus.wdata[POS_SECOND_PD];
					st_nxt.first_pd    = bus.wdata[POS_FIRST_PD];
					st_nxt.clear_n     = bus.wdata[POS_CLEAR_N];
					st_nxt.order       = bus.wdata[POS_ORDER +: 3];
				end
				OFS_FIRST_SEL:
				begin
					st_nxt.first_src = bus.wdata[POS_FIRST_SRC +: 2];
					st_nxt.boost     = bus.wdata[POS_BOOST +: 2];
					st_nxt.second_level =
						bus.wdata[POS_SECOND_LEVEL +: 6];
				end
				OFS_SECOND_SEL:
					st_nxt.second_src = bus.wdata[POS_SECOND_SRC +: 2];
				OFS_PIN_CFG:
				begin
					st_nxt.pin.disregard  = bus.wdata[POS_PIN_IGNORE];
					st_nxt.pin.hysteresis = bus.wdata[POS_PIN_HYST];
					st_nxt.pin.bias_level = bus.wdata[POS_PIN_LEVEL +: 2];
					st_nxt.pin.format     = bus.wdata[POS_PIN_FORMAT +: 3];
				end
				default:
					st_nxt.seed_load = 1'b0;   // unmapped: no effect
			endcase
		end

		// reads answer next cycle; fixed bits read as their pattern
		if (bus.rd)
		begin
			case (bus.addr)
				OFS_FB_HIGH:
					st_nxt.rd_data = ffd_word_t'(st_r.fb_div[DIV_W-1:16]);
				OFS_FB_LOW:
					st_nxt.rd_data = st_r.fb_div[15:0];
				OFS_SEED_DELAY:
					st_nxt.rd_data = FIX_SEED_DELAY
					   | (ffd_word_t'(st_r.seed_en) << POS_SEED_EN)
					   | (ffd_word_t'(st_r.dly_sel) << POS_DELAY_SEL);
				OFS_DEN_HIGH:
					st_nxt.rd_data = st_r.den[31:16];
				OFS_DEN_LOW:
					st_nxt.rd_data = st_r.den[15:0];
				OFS_SEED_HIGH:
					// the gathered seed, not the last write
					st_nxt.rd_data = st_r.seed_acc[31:16];
				OFS_SEED_LOW:
					st_nxt.rd_data = st_r.seed_acc[15:0];
				OFS_NUM_HIGH:
					st_nxt.rd_data = st_r.num[31:16];
				OFS_NUM_LOW:
					st_nxt.rd_data = st_r.num[15:0];
				OFS_OUT_MOD:
					st_nxt.rd_data =
					     (ffd_word_t'(st_r.first_level) << POS_FIRST_LEVEL)
					   | (ffd_word_t'(st_r.second_pd) << POS_SECOND_PD)
					   | (ffd_word_t'(st_r.first_pd) << POS_FIRST_PD)
					   | (ffd_word_t'(st_r.clear_n) << POS_CLEAR_N)
					   | (ffd_word_t'(st_r.order) << POS_ORDER);
				OFS_FIRST_SEL:
					st_nxt.rd_data = FIX_FIRST_SEL
					   | (ffd_word_t'(st_r.first_src) << POS_FIRST_SRC)
					   | (ffd_word_t'(st_r.boost) << POS_BOOST)
					   | (ffd_word_t'(st_r.second_level) << POS_SECOND_LEVEL);
				OFS_SECOND_SEL:
					st_nxt.rd_data = FIX_SECOND_SEL
					   | (ffd_word_t'(st_r.second_src) << POS_SECOND_SRC);
				OFS_PIN_CFG:
					st_nxt.rd_data = FIX_PIN_CFG
					   | (ffd_word_t'(st_r.pin.disregard) << POS_PIN_IGNORE)
					   | (ffd_word_t'(st_r.pin.hysteresis) << POS_PIN_HYST)
					   | (ffd_word_t'(st_r.pin.bias_level) << POS_PIN_LEVEL)
					   | (ffd_word_t'(st_r.pin.format) << POS_PIN_FORMAT);
				default:
					st_nxt.rd_data = '0;       // unmapped reads as zero
			endcase
		end

		// effective divide: integer part plus the modulator carry
		st_nxt.frac_on = frac_allowed(st_r.order, st_r.clear_n);
		st_nxt.div_out = {1'b0, st_r.fb_div}
		               + (DIV_W+1)'(st_r.frac_on && carry);

		// output driver settings follow the fields
		st_nxt.out.first_level   = st_r.first_level;
		st_nxt.out.first_pd      = st_r.first_pd;
		st_nxt.out.first_src     = st_r.first_src;
		// the reserved first source code is kept quiet like hi-z
		st_nxt.out.first_active  =
			out_drives(st_r.first_pd, st_r.first_src, 1'b1);
		st_nxt.out.second_level  = st_r.second_level;
		st_nxt.out.second_pd     = st_r.second_pd;
		st_nxt.out.second_src    = st_r.second_src;
		st_nxt.out.second_active =
			out_drives(st_r.second_pd, st_r.second_src, 1'b0);
		st_nxt.out.boost         = st_r.boost;

		// board request pins pass only when not disregarded
		st_nxt.sync_q   = !st_r.pin.disregard && sync_pin;
		st_nxt.sysref_q = !st_r.pin.disregard && sysref_req_pin;
	end

	// state register; constants only under reset
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			st_r              <= '0;
			st_r.fb_div       <= RST_FB_DIVIDE;
			st_r.dly_sel      <= RST_DELAY_SEL;
			st_r.den          <= RST_DEN;
			st_r.first_level  <= RST_LEVEL;
			st_r.second_pd    <= 1'b1;
			st_r.first_pd     <= 1'b0;
			st_r.clear_n      <= 1'b1;
			st_r.order        <= RST_ORDER;
			st_r.first_src    <= RST_SRC;
			st_r.second_level <= RST_LEVEL;
			st_r.second_src   <= RST_SRC;
			st_r.pin.disregard <= 1'b1;
			st_r.div_out      <= {1'b0, RST_FB_DIVIDE};
			st_r.out.first_level  <= RST_LEVEL;
			st_r.out.first_src    <= RST_SRC;
			st_r.out.first_active <= 1'b1;
			st_r.out.second_level <= RST_LEVEL;
			st_r.out.second_pd    <= 1'b1;
			st_r.out.second_src   <= RST_SRC;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// every output straight from the state register
	assign rd_data               = st_r.rd_data;
	assign feedback_divide       = st_r.div_out;
	assign frac_active           = st_r.frac_on;
	assign detector_delay_select = st_r.dly_sel;
	assign out_ctrl              = st_r.out;
	assign pin_cfg               = st_r.pin;
	assign sync_req              = st_r.sync_q;
	assign sysref_req            = st_r.sysref_q;

endmodule

// file: ffd_regs_checker.sv
// concurrent checks on the ports of the fractional divider register set
// assumes it is bound to ffd_regs, one clock, asynchronous high reset
`timescale 1ns/1ps
module ffd_regs_checker
	import ffd_pkg::*;
(
	// clock and reset
	input wire logic                      ref_clk,
	input wire logic                      reset,
	// register port
	input wire ffd_pkg::ffd_bus_t         bus,
	input wire logic [ffd_pkg::DATA_W-1:0] rd_data,
	// settings and gated pins
	input wire logic [ffd_pkg::DIV_W:0]   feedback_divide,
	input wire logic                      frac_active,
	input wire ffd_pkg::ffd_out_t         out_ctrl,
	input wire ffd_pkg::ffd_pin_cfg_t     pin_cfg,
	input wire logic                      sync_pin,
	input wire logic                      sysref_req_pin,
	input wire logic                      sync_req,
	input wire logic                      sysref_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// writes aimed at the two output control words
	sequence s_wr_out;
		bus.wr && bus.addr == OFS_OUT_MOD;
	endsequence
	sequence s_wr_sel;
		bus.wr && bus.addr == OFS_FIRST_SEL;
	endsequence
	// written word kept in a local so the later check can see it
	property p_order;
		ffd_word_t v;
		(s_wr_out, v = bus.wdata) |-> ##2 frac_active ==
		(v[5] && v[2:0] != 3'h0 && v[2:0] <= ORDER_MAX);
	endproperty
	property p_out;
		ffd_word_t v;
		(s_wr_out, v = bus.wdata) |-> ##2
		out_ctrl.first_level == v[13:8] && out_ctrl.second_pd == v[7]
		&& out_ctrl.first_pd == v[6];
	endproperty
	property p_sel;
		ffd_word_t v;
		(s_wr_sel, v = bus.wdata) |-> ##2
		out_ctrl.first_src == v[12:11] && out_ctrl.boost == v[10:9]
		&& out_ctrl.second_level == v[5:0];
	endproperty
	property p_second_src;
		ffd_word_t v;
		(bus.wr && bus.addr == OFS_SECOND_SEL, v = bus.wdata)
		|-> ##2 out_ctrl.second_src == v[1:0];
	endproperty
	property p_pin;
		ffd_word_t v;
		(bus.wr && bus.addr == OFS_PIN_CFG, v = bus.wdata)
		|-> ##2 pin_cfg.disregard == v[15] && pin_cfg.format == v[11:9];
	endproperty
	// read data only in the cycle after a read strobe
	chk_read_idle: assert property (
		!$past(bus.rd) |-> rd_data == '0)
		else $error("read data outside its answer cycle");
	chk_reset_values: assert property (
		$fell(reset) |-> feedback_divide == 20'h0_0064 && !frac_active
		&& out_ctrl.second_pd && !out_ctrl.first_pd && pin_cfg.disregard)
		else $error("wrong settings after reset");
	// order 1..4 with clear released runs the fraction, all else integer
	chk_order_active: assert property (p_order)
		else $error("fraction enable does not follow order and clear");
	chk_out_fields: assert property (p_out)
		else $error("output level or powerdown not taken");
	chk_sel_fields: assert property (p_sel)
		else $error("first source, boost or second level not taken");
	chk_second_src: assert property (p_second_src)
		else $error("second source not taken");
	// high impedance sources never drive; the reserved source is quiet on the first output only
	chk_first_active: assert property (
		out_ctrl.first_active == (!out_ctrl.first_pd
		&& out_ctrl.first_src != SRC_HIGH_Z
		&& out_ctrl.first_src != SRC_RESERVED))
		else $error("first output activity wrong");
	chk_second_active: assert property (
		out_ctrl.second_active == (!out_ctrl.second_pd
		&& out_ctrl.second_src != SRC_HIGH_Z))
		else $error("second output activity wrong");
	chk_pin_write: assert property (p_pin)
		else $error("pin configuration not taken");
	// request pins pass one cycle late unless disregarded
	chk_sync_gate: assert property (
		sync_req == ($past(sync_pin) && !$past(pin_cfg.disregard)))
		else $error("sync request gating wrong");
	chk_sysref_gate: assert property (
		sysref_req == ($past(sysref_req_pin) && !$past(pin_cfg.disregard)))
		else $error("sysref request gating wrong");
endmodule

bind ffd_regs ffd_regs_checker i_ffd_regs_checker (
	.ref_clk(ref_clk), .reset(reset), .bus(bus), .rd_data(rd_data),
	.feedback_divide(feedback_divide), .frac_active(frac_active),
	.out_ctrl(out_ctrl), .pin_cfg(pin_cfg), .sync_pin(sync_pin),
	.sysref_req_pin(sysref_req_pin), .sync_req(sync_req),
	.sysref_req(sysref_req));

// file: ffd_regs_test.sv
// self-checking bench for the fractional divider register set
// assumes ffd_regs with its bound checker and a 100 MHz clock
`timescale 1ns/1ps
module ffd_regs_test;
	import ffd_pkg::*;
	// offset, value written, reset value, value read back
	typedef struct {
		ffd_addr_t a;
		ffd_word_t w;
		ffd_word_t r;
		ffd_word_t e;
	} ffd_row_t;
	localparam logic [DIV_W:0] N_VAL = 20'h1_2345; // divide set by the table
	// design ports
	logic              ref_clk = 1'h0;
	logic              reset = 1'h1;
	ffd_bus_t          bus = '0;
	logic [DATA_W-1:0] rd_data;
	logic              frac_step_en = 1'h0;
	logic              sync_pin = 1'h0;
	logic              sysref_req_pin = 1'h0;
	logic [DIV_W:0]    feedback_divide;
	logic              frac_active;
	logic [5:0]        delay_sel;
	ffd_out_t          out_ctrl;
	ffd_pin_cfg_t      pin_cfg;
	logic              sync_req;
	logic              sysref_req;
	// tallies
	int                n_fail = 0;
	int                comparisons = 0;
	// values keep the fixed bits; last row is unmapped
	ffd_row_t rows [12] = '{
		'{7'h22, 16'h0001, 16'h0000, 16'h0001},
		'{7'h24, 16'h2345, 16'h0064, 16'h2345},
		'{7'h25, 16'h8A04, 16'h0204, 16'h8A04},
		'{7'h26, 16'h0000, 16'hFFFF, 16'h0000},
		'{7'h27, 16'h0002, 16'hFFFF, 16'h0002},
		'{7'h2a, 16'h0000, 16'h0000, 16'h0000},
		'{7'h2b, 16'h0001, 16'h0000, 16'h0001},
		'{7'h2c, 16'h0A21, 16'h1FA0, 16'h0A21},
		'{7'h2d, 16'hC655, 16'hC85F, 16'hC655},
		'{7'h2e, 16'h07FE, 16'h07FD, 16'h07FE},
		'{7'h3a, 16'h5601, 16'h8001, 16'h5601},
		'{7'h30, 16'hFFFF, 16'h0000, 16'h0000}
	};

	always #5 ref_clk = ~ref_clk;

	ffd_regs i_ffd_regs (
		.ref_clk(ref_clk), .reset(reset), .bus(bus), .rd_data(rd_data),
		.frac_step_en(frac_step_en), .sync_pin(sync_pin),
		.sysref_req_pin(sysref_req_pin), .feedback_divide(feedback_divide),
		.frac_active(frac_active), .detector_delay_select(delay_sel),
		.out_ctrl(out_ctrl), .pin_cfg(pin_cfg), .sync_req(sync_req),
		.sysref_req(sysref_req));

	// case-equal compare, so unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input ffd_addr_t a, input ffd_word_t d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge ref_clk);
		bus.wr <= 1'h0;
	endtask
	// one-cycle read strobe, answer sampled in the next cycle only
	task automatic rd(input ffd_addr_t a, input ffd_word_t e);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
		@(posedge ref_clk);
		bus.rd <= 1'h0;
		#1 chk(32'(rd_data), 32'(e));
	endtask
	// let a write reach the derived outputs
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	// one modulator step; the divide shows it two cycles later
	task automatic step(input logic [DIV_W:0] e);
		@(posedge ref_clk);
		frac_step_en <= 1'h1;
		@(posedge ref_clk);
		frac_step_en <= 1'h0;
		@(posedge ref_clk);
		#1 chk(32'(feedback_divide), 32'(e));
	endtask
	// single exit with the verdict
	task automatic end_sim;
		$display("comparisons %0d, n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// guard against a hang
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		$display("mismatch at %0t: run limit %h reached %h", $time, 0, 1);
		end_sim();
	end

	initial
	begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'h0;
		// reset values, registers then ports
		foreach (rows[i])
			rd(rows[i].a, rows[i].r);
		chk(32'(feedback_divide), 32'h0000_0064);
		chk(32'(out_ctrl), 32'({6'h1F, 1'h0, 2'h1, 1'h1, 6'h1F, 1'h1,
			2'h1, 1'h0, 2'h0}));
		chk(32'(pin_cfg), 32'h0000_0040);
		chk(32'({delay_sel, frac_active}), 32'h0000_0004);
		$display("test reset done");
		// table: write each register, read it back
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		chk(32'(feedback_divide), 32'(N_VAL));
		chk(32'(out_ctrl), 32'({6'h0A, 1'h0, 2'h0, 1'h1, 6'h15, 1'h0,
			2'h2, 1'h1, 2'h3}));
		chk(32'(pin_cfg), 32'h0000_002B);
		chk(32'({delay_sel, frac_active}), 32'h0000_0015);
		$display("test table done");
		// num 1 over den 2 from a zero start: carry every second step
		step(N_VAL);
		step(N_VAL + 20'h0_0001);
		step(N_VAL);
		step(N_VAL + 20'h0_0001);
		$display("test fraction done");
		// seed of one with apply enabled carries on the first step
		rd(7'h29, 16'h0000);
		wr(7'h28, 16'h0000);
		wr(7'h29, 16'h0001);
		rd(7'h29, 16'h0001);
		step(N_VAL + 20'h0_0001);
		step(N_VAL);
		wr(7'h28, 16'h0000);
		wr(7'h29, 16'h0001);
		rd(7'h29, 16'h0002);
		rd(7'h28, 16'h0000);
		// clear held low: seed wiped, fraction ignored
		wr(7'h2c, 16'h0A01);
		settle();
		chk(32'(frac_active), 32'h0000_0000);
		rd(7'h29, 16'h0000);
		step(N_VAL);
		// apply disabled: seed written but start stays zero
		wr(7'h2c, 16'h0A21);
		wr(7'h25, 16'h0A04);
		wr(7'h28, 16'h0000);
		wr(7'h29, 16'h0001);
		step(N_VAL);
		step(N_VAL + 20'h0_0001);
		$display("test seed done");
		// every order code, reserved ones act as integer
		for (int o = 0; o < 8; o++)
		begin
			wr(7'h2c, 16'h0A20 | 16'(o));
			settle();
			chk(32'(frac_active), 32'(o >= 1 && o <= 4));
		end
		$display("test order done");
		// reserved first source and high impedance second source
		wr(7'h2d, 16'hD655);
		wr(7'h2e, 16'h07FF);
		settle();
		chk(32'({out_ctrl.first_active, out_ctrl.second_active}),
			32'h0000_0000);
		$display("test sources done");
		// request pins used, then disregarded
		@(posedge ref_clk);
		sync_pin <= 1'h1;
		sysref_req_pin <= 1'h1;
		settle();
		chk(32'({sync_req, sysref_req}), 32'h0000_0003);
		@(posedge ref_clk);
		sync_pin <= 1'h0;
		sysref_req_pin <= 1'h0;
		wr(7'h3a, 16'h8001);
		@(posedge ref_clk);
		sync_pin <= 1'h1;
		sysref_req_pin <= 1'h1;
		settle();
		chk(32'({sync_req, sysref_req}), 32'h0000_0000);
		$display("test pins done");
		// mid-run reset brings the defaults back
		@(posedge ref_clk);
		reset <= 1'h1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
		#1 chk(32'(feedback_divide), 32'h0000_0064);
		chk(32'(pin_cfg), 32'h0000_0040);
		chk(32'({sync_req, sysref_req}), 32'h0000_0000);
		rd(7'h2c, 16'h1FA0);
		$display("test second reset done");
		end_sim();
	end
endmodule
